/* File: shared/adc_result_pkg.sv */
// constants, field layouts and carrier types for the converter result bank
// assumes one 25 MHz system clock; results arrive from on-chip converter logic
package adc_result_pkg;
    localparam int unsigned CODE_W = 7;
    localparam int unsigned REG_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FLAG_BIT = 7;

    // register offsets
    localparam logic [7:0] OFF_BATTERY = 8'h0E;
    localparam logic [7:0] OFF_SYSTEM = 8'h0F;
    localparam logic [7:0] OFF_THERMISTOR = 8'h10;
    localparam logic [7:0] OFF_INPUT = 8'h11;
    localparam logic [7:0] OFF_CURRENT = 8'h12;

    // reset values: base code of all zeros, flags clear
    localparam logic [6:0] CODE_BASE = 7'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    // scale of each code, in its own unit (informative to software)
    localparam int unsigned BATT_BASE_MV = 2304;
    localparam int unsigned BATT_STEP_MV = 20;
    localparam int unsigned SYS_BASE_MV = 2304;
    localparam int unsigned SYS_STEP_MV = 20;
    localparam int unsigned TS_BASE_PCT_X1000 = 21000;
    localparam int unsigned TS_STEP_PCT_X1000 = 465;
    localparam int unsigned IN_BASE_MV = 2600;
    localparam int unsigned IN_STEP_MV = 100;
    localparam int unsigned CHG_BASE_MA = 0;
    localparam int unsigned CHG_STEP_MA = 50;

    typedef enum logic [2:0] {
        CH_BATTERY = 3'b000,
        CH_SYSTEM = 3'b001,
        CH_THERMISTOR = 3'b010,
        CH_INPUT = 3'b011,
        CH_CURRENT = 3'b100
    } channel_e;

    localparam int unsigned NUM_CH = 5;

    // one finished conversion, delivered whole
    typedef struct packed {
        logic valid;
        channel_e channel;
        logic [6:0] code;
    } conv_result_s;

    // live status levels from the charger core
    typedef struct packed {
        logic thermal_reg_flag;
        logic input_present_flag;
        logic below_battery_short_threshold;
    } charger_status_s;

    // host register port
    typedef struct packed {
        logic rd_en;
        logic [7:0] addr;
    } reg_req_s;
endpackage

/* File: core/adc_result_status_regs.sv */
// read-only measurement and status bank seen by the host over the serial port
// assumes the serial slave presents addr/rd_en on clk_sys; status inputs are pins
// What this block does
// [R1] battery register top bit reports thermal regulation, zero when normal
// [R2] battery code: 20 mV steps above 2.304 V, seven bits
// [R3] system code: same 2.304 V base and 20 mV step
// [R4] top bit of system, thermistor and current registers always reads zero
// [R5] thermistor code: 0.465 percent steps above 21 percent of regulator rail
// [R6] input register top bit shows input source attached
// [R7] input code: 100 mV steps above 2.6 V
// [R8] charge current code: 50 mA steps from zero
// [R9] charge current reads zero while battery is below short threshold
// [R10] every code stays at zero until a conversion lands
// [R11] the bank is read only; host writes change nothing
// [R12] each code is replaced whole, never mixed between conversions
module adc_result_status_regs
    import adc_result_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire adc_result_pkg::conv_result_s conv_in,
    input wire adc_result_pkg::charger_status_s status_pin,
    input wire adc_result_pkg::reg_req_s req,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    import adc_result_pkg::*;

    // status levels come from analog comparators: two-flop synchroniser
    charger_status_s sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic [6:0] code_ff [NUM_CH];
    logic [6:0] nxt_code [NUM_CH];
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic rd_valid_ff, nxt_rd_valid;
    logic [7:0] reg_view [NUM_CH];

    always_comb begin
        nxt_sync1 = status_pin;
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_code
            always_comb begin
                nxt_code[gi] = code_ff[gi];
                // [R12] whole-code update
                if (conv_in.valid && conv_in.channel == channel_e'(gi)) begin
                    nxt_code[gi] = conv_in.code;
                end
            end

            always_ff @(posedge clk_sys) begin
                // [R10] base code after reset
                if (rst) begin
                    code_ff[gi] <= CODE_BASE;
                end else begin
                    code_ff[gi] <= nxt_code[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        // [R1] thermal flag on battery register
        reg_view[CH_BATTERY] = {sync2_ff.thermal_reg_flag, code_ff[CH_BATTERY]};
        // [R4] unused top bits read zero
        reg_view[CH_SYSTEM] = {1'b0, code_ff[CH_SYSTEM]};
        reg_view[CH_THERMISTOR] = {1'b0, code_ff[CH_THERMISTOR]};
        // [R6] input attached flag
        reg_view[CH_INPUT] = {sync2_ff.input_present_flag, code_ff[CH_INPUT]};
        // [R9] current forced to zero below short threshold
        reg_view[CH_CURRENT] = sync2_ff.below_battery_short_threshold
            ? {1'b0, CODE_BASE} : {1'b0, code_ff[CH_CURRENT]};
    end

    // [R2] [R3] [R5] [R7] [R8] codes pass unscaled; software applies base and step
    always_comb begin
        nxt_rd_valid = req.rd_en;
        nxt_rd_data = rd_data_ff;
        if (req.rd_en) begin
            if (req.addr == OFF_BATTERY) begin
                nxt_rd_data = reg_view[CH_BATTERY];
            end else if (req.addr == OFF_SYSTEM) begin
                nxt_rd_data = reg_view[CH_SYSTEM];
            end else if (req.addr == OFF_THERMISTOR) begin
                nxt_rd_data = reg_view[CH_THERMISTOR];
            end else if (req.addr == OFF_INPUT) begin
                nxt_rd_data = reg_view[CH_INPUT];
            end else if (req.addr == OFF_CURRENT) begin
                nxt_rd_data = reg_view[CH_CURRENT];
            end else begin
                nxt_rd_data = UNMAPPED_VALUE;
            end
        end
    end

    // [R11] wr_en and wr_data are deliberately never read into state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data_ff <= REG_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;

    a_current_short_zero: assert property ( // [R9]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && req.addr == OFF_CURRENT && sync2_ff.below_battery_short_threshold
        |=> rd_data == 8'h00)
        else $error("current code not zero below short threshold");

    a_top_bit_zero: assert property ( // [R4]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && (req.addr == OFF_SYSTEM || req.addr == OFF_THERMISTOR
            || req.addr == OFF_CURRENT) |=> !rd_data[FLAG_BIT])
        else $error("unused top bit read as one");

    a_thermal_flag_read: assert property ( // [R1]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && req.addr == OFF_BATTERY
        |=> rd_data[FLAG_BIT] == $past(sync2_ff.thermal_reg_flag))
        else $error("thermal flag mismatch");

    a_input_flag_read: assert property ( // [R6]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && req.addr == OFF_INPUT
        |=> rd_data[FLAG_BIT] == $past(sync2_ff.input_present_flag))
        else $error("input flag mismatch");

    a_battery_code_load: assert property ( // [R2]
        @(posedge clk_sys) disable iff (rst)
        conv_in.valid && conv_in.channel == CH_BATTERY
        ##1 req.rd_en && req.addr == OFF_BATTERY && !conv_in.valid
        |=> rd_data[6:0] == $past(conv_in.code, 2))
        else $error("battery code not loaded");

    a_system_code_load: assert property ( // [R3]
        @(posedge clk_sys) disable iff (rst)
        conv_in.valid && conv_in.channel == CH_SYSTEM
        |=> code_ff[CH_SYSTEM] == $past(conv_in.code))
        else $error("system code not loaded");

    a_ts_input_load: assert property ( // [R5]
        @(posedge clk_sys) disable iff (rst)
        conv_in.valid && conv_in.channel == CH_THERMISTOR
        |=> code_ff[CH_THERMISTOR] == $past(conv_in.code)
            && $stable(code_ff[CH_INPUT]))
        else $error("thermistor code not loaded or input disturbed");

    a_hold_no_conv: assert property ( // [R12]
        @(posedge clk_sys) disable iff (rst)
        !conv_in.valid |=> $stable(code_ff[CH_INPUT]) && $stable(code_ff[CH_CURRENT]))
        else $error("code changed without conversion");

    a_reset_base: assert property ( // [R10]
        @(posedge clk_sys)
        $fell(rst) |-> code_ff[CH_BATTERY] == CODE_BASE && code_ff[CH_CURRENT] == CODE_BASE)
        else $error("code not at base after reset");

    a_write_ignored: assert property ( // [R11]
        @(posedge clk_sys) disable iff (rst)
        wr_en && !conv_in.valid |=> $stable(code_ff[CH_BATTERY]))
        else $error("write changed a code");

    a_input_code_load: assert property ( // [R7]
        @(posedge clk_sys) disable iff (rst)
        conv_in.valid && conv_in.channel == CH_INPUT
        |=> code_ff[CH_INPUT] == $past(conv_in.code)
            && $stable(code_ff[CH_THERMISTOR]))
        else $error("input code not loaded or thermistor disturbed");

    a_current_code_load: assert property ( // [R8]
        @(posedge clk_sys) disable iff (rst)
        conv_in.valid && conv_in.channel == CH_CURRENT
        |=> code_ff[CH_CURRENT] == $past(conv_in.code)
            && $stable(code_ff[CH_BATTERY]))
        else $error("current code not loaded or battery disturbed");

    a_battery_read_code: assert property ( // [R2]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && req.addr == OFF_BATTERY
        |=> rd_data[6:0] == $past(code_ff[CH_BATTERY]))
        else $error("battery code read wrong");

    a_system_read_code: assert property ( // [R3]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && req.addr == OFF_SYSTEM
        |=> rd_data == {1'b0, $past(code_ff[CH_SYSTEM])})
        else $error("system code read wrong");

    a_current_read_code: assert property ( // [R8]
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && req.addr == OFF_CURRENT && !sync2_ff.below_battery_short_threshold
        |=> rd_data == {1'b0, $past(code_ff[CH_CURRENT])})
        else $error("current code read wrong while battery healthy");

    a_read_hold: assert property ( // [R12]
        @(posedge clk_sys) disable iff (rst)
        !req.rd_en |=> $stable(rd_data) && !rd_valid)
        else $error("read data moved without a read");

    a_reset_outputs: assert property ( // [R10]
        @(posedge clk_sys)
        $fell(rst) |-> rd_data == REG_RESET && !rd_valid)
        else $error("read port not cleared by reset");
endmodule // adc_result_status_regs

/* File: test/host_reader.sv */
// host side of the register port: one-cycle read strobes and ignored writes
// assumes clk_sys from the bench and the bank's registered one-cycle answer
module host_reader
    import adc_result_pkg::*;
(
    input wire logic clk_sys,
    output adc_result_pkg::reg_req_s req,
    output logic wr_en,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    import adc_result_pkg::*;
    initial begin
        req = '{rd_en: 1'b0, addr: 8'hFF};
        wr_en = 1'b0;
        wr_data = 8'hA5;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok,
        output int lat);
        ok = 1'b0;
        d = 8'h00;
        lat = -1;
        @(posedge clk_sys);
        req <= '{rd_en: 1'b1, addr: a};
        @(posedge clk_sys);
        req.rd_en <= 1'b0;
        // released address flips so a stale decode cannot pass
        req.addr <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk_sys);
            if (rd_valid === 1'b1) begin
                d = rd_data;
                ok = 1'b1;
                lat = i;
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        wr_en <= 1'b1;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
endmodule // host_reader

/* File: test/adc_result_status_regs_test.sv */
// self-checking bench for the converter result bank
// assumes a 25 MHz clock; host_reader plays the serial host
module adc_result_status_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_result_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    conv_result_s conv_in = '0;
    charger_status_s status_pin = '0;
    reg_req_s req;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rd_valid;
    int miscompares = 0;
    int checked = 0;
    always #20 clk_sys = ~clk_sys;
    adc_result_status_regs dut (.clk_sys(clk_sys), .rst(rst), .conv_in(conv_in),
        .status_pin(status_pin), .req(req), .wr_en(wr_en), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid));
    host_reader host (.clk_sys(clk_sys), .req(req), .wr_en(wr_en), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid));
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_lat(input int got, input int exp);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] %0t latency got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic judge(input logic [7:0] a, input logic [7:0] d, input bit ok,
        input int lat, input logic [7:0] exp);
        if (!ok) begin
            miscompares++;
            $display("[FAIL] %0t no answer at %h", $time, a);
            close_out();
        end else begin
            chk(d, exp);
            chk_lat(lat, 0);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        int lat;
        host.rd(a, d, ok, lat);
        judge(a, d, ok, lat, exp);
    endtask
    task automatic conv(input logic [2:0] ch, input logic [6:0] code);
        @(posedge clk_sys);
        conv_in <= '{valid: 1'b1, channel: channel_e'(ch), code: code};
        @(posedge clk_sys);
        conv_in <= '{valid: 1'b0, channel: channel_e'(ch), code: ~code};
    endtask
    task automatic set_status(input logic t, input logic i, input logic s);
        @(posedge clk_sys);
        status_pin <= '{thermal_reg_flag: t, input_present_flag: i,
            below_battery_short_threshold: s};
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        for (int a = 8'h0E; a <= 8'h13; a++) rd_chk(8'(a), 8'h00);
    endtask
    task automatic t_codes();
        // distinct codes per channel so a crossed decode shows up
        for (int c = 0; c < 5; c++) begin
            conv(3'(c), 7'(8'h40 + c));
            rd_chk(OFF_BATTERY + 8'(c), 8'(8'h40 + c));
        end
        conv(3'h5, 7'h00);
        for (int c = 0; c < 5; c++) rd_chk(OFF_BATTERY + 8'(c), 8'(8'h40 + c));
        rd_chk(8'h13, 8'h00);
        rd_chk(8'h0D, 8'h00);
        conv(3'h0, 7'h2A);
        rd_chk(OFF_BATTERY, 8'h2A);
        for (int c = 0; c < 5; c++) conv(3'(c), 7'h7F);
    endtask
    task automatic t_flags();
        set_status(1'b1, 1'b1, 1'b0);
        rd_chk(OFF_BATTERY, 8'hFF);
        rd_chk(OFF_INPUT, 8'hFF);
        rd_chk(OFF_SYSTEM, 8'h7F);
        rd_chk(OFF_THERMISTOR, 8'h7F);
        rd_chk(OFF_CURRENT, 8'h7F);
        set_status(1'b1, 1'b0, 1'b0);
        rd_chk(OFF_BATTERY, 8'hFF);
        rd_chk(OFF_INPUT, 8'h7F);
        set_status(1'b0, 1'b1, 1'b0);
        rd_chk(OFF_BATTERY, 8'h7F);
        rd_chk(OFF_INPUT, 8'hFF);
        set_status(1'b0, 1'b0, 1'b0);
        rd_chk(OFF_BATTERY, 8'h7F);
        rd_chk(OFF_INPUT, 8'h7F);
    endtask
    task automatic t_short();
        set_status(1'b0, 1'b0, 1'b1);
        rd_chk(OFF_CURRENT, 8'h00);
        rd_chk(OFF_BATTERY, 8'h7F);
        set_status(1'b0, 1'b0, 1'b0);
        rd_chk(OFF_CURRENT, 8'h7F);
    endtask
    task automatic t_write();
        host.wr(OFF_BATTERY, 8'h00);
        host.wr(OFF_CURRENT, 8'h80);
        rd_chk(OFF_BATTERY, 8'h7F);
        rd_chk(OFF_CURRENT, 8'h7F);
    endtask
    task automatic t_fresh();
        logic [7:0] d;
        bit ok;
        int lat;
        // read strobe lands the cycle right after the conversion pulse
        @(posedge clk_sys);
        conv_in <= '{valid: 1'b1, channel: CH_BATTERY, code: 7'h15};
        fork
            host.rd(OFF_BATTERY, d, ok, lat);
            begin
                @(posedge clk_sys);
                conv_in <= '{valid: 1'b0, channel: CH_BATTERY, code: 7'h6A};
            end
        join
        judge(OFF_BATTERY, d, ok, lat, 8'h15);
    endtask
    task automatic t_rerun();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 8'h0E; a <= 8'h12; a++) rd_chk(8'(a), 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_flags();
        t_short();
        t_write();
        t_fresh();
        t_rerun();
        close_out();
    end
endmodule // adc_result_status_regs_test
